// ==== design/pattern_trigger_pkg.sv ====
package pattern_trigger_pkg;

  // ==========================================================================
  // register map (byte addresses on the AXI4-Lite slave)
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_SEQ_EN   = 8'h04;
  localparam logic [7:0]  OFF_PATTERN  = 8'h08;
  localparam logic [7:0]  OFF_LENGTH   = 8'h0c;
  localparam logic [7:0]  OFF_STATUS   = 8'h10;
  localparam logic [7:0]  OFF_MKR_BASE = 8'h80;  // 32 words, one per point

  // register selectors produced by the address decoder
  localparam logic [2:0]  SEL_CTRL     = 3'h0;
  localparam logic [2:0]  SEL_SEQ_EN   = 3'h1;
  localparam logic [2:0]  SEL_PATTERN  = 3'h2;
  localparam logic [2:0]  SEL_LENGTH   = 3'h3;
  localparam logic [2:0]  SEL_STATUS   = 3'h4;
  localparam logic [2:0]  SEL_MKR      = 3'h5;
  localparam logic [2:0]  SEL_NONE     = 3'h7;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ==========================================================================
  // timing: clock 10 MHz, data bit clock is a division of it
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          BIT_DIV       = 4;      // clock cycles per bit
  localparam logic [1:0]  PH_FALL       = 2'h1;   // last phase with clock high
  localparam logic [1:0]  PH_RISE       = 2'h3;   // last phase of a bit

  // ==========================================================================
  // field layouts and reset values
  localparam int          PTS          = 32;     // pattern bits / wave points
  localparam logic [4:0]  PLEN_RST     = 5'h1f;
  localparam logic [3:0]  SLEN_RST     = 4'h7;
  localparam logic [31:0] PATTERN_RST  = 32'h0000_0000;
  localparam logic [1:0]  SEQ_EN_RST   = 2'h0;

  typedef struct packed {
    logic seq_mode;    // markers come from a combined sequence
    logic pol4_neg;    // fourth marker active low
    logic pol3_neg;    // third marker active low
    logic src_ext;     // serial data from the external data input
    logic wave_mode;   // arbitrary waveform mode
    logic continuous;  // repeat the pattern
    logic edge_fall;   // trigger on the falling edge
  } ctrl_type;

  localparam ctrl_type    CTRL_RST     = 7'h00;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } state_type;

endpackage

// ==== design/pattern_trigger_marker_io.sv ====
// Contract
// - Trigger on rising or falling edge of the trigger input, software selected.
// - Trigger starts one pattern in single mode; stops and resyncs continuous output.
// - Latch the trigger edge, then sample it on the bit clock falling edge.
// - First frame bit appears 1.5 to 2.5 bit periods after trigger edge; the code takes 1.75 to 2.75.
// - Trigger input also triggers the arbitrary waveform generator.
// - Third marker output asserted per point flag, high or low by polarity.
// - Fourth marker output asserted per point flag, level set by polarity.
// - Segment markers enabled; in sequence mode disabled until re-enabled.
// - Second trigger input starts a single pattern output.
// - Symbol sync pulse marks each symbol start, one bit period wide.
// - Data bit clock is driven on the bit clock output.
// - Serial data comes from internal pattern or external data input.
// - Each waveform point holds its own on/off flag per marker.
`timescale 1ns/1ps
`default_nettype none
module pattern_trigger_marker_io
  import pattern_trigger_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PATTERN_TRIGGER_INPUT,
  input  wire logic        SECOND_PATTERN_TRIGGER_INPUT,
  input  wire logic        EXT_DATA_IN,
  output logic             DATA_CLK_OUT,
  output logic             DATA_OUT,
  output logic             SYMBOL_SYNC_OUTPUT,
  output logic             MARKER3_OUT,
  output logic             MARKER4_OUT,
  output logic             WAVE_TRIG_OUT,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  // ==========================================================================
  // functions

  // address to register selector, used by both write and read paths
  function automatic logic [2:0] decode(input logic [7:0] a);
    logic [2:0] s;
    s = SEL_NONE;
    if (a[1:0] != 2'h0) s = SEL_NONE;
    else if (a[7]) s = SEL_MKR;
    else if (a == OFF_CTRL) s = SEL_CTRL;
    else if (a == OFF_SEQ_EN) s = SEL_SEQ_EN;
    else if (a == OFF_PATTERN) s = SEL_PATTERN;
    else if (a == OFF_LENGTH) s = SEL_LENGTH;
    else if (a == OFF_STATUS) s = SEL_STATUS;
    return s;
  endfunction

  // selected edge between the previous and the current input level
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic fall);
    return fall ? (prev & ~cur) : (~prev & cur);
  endfunction

  // ==========================================================================
  // declarations
  ctrl_type    ctrl_r;
  logic [1:0]  seq_en_r;
  logic [31:0] pattern_r;
  logic [4:0]  plen_r;
  logic [3:0]  slen_r;
  logic [1:0]  mkr_mem [0:PTS-1];

  logic        aw_have_r, w_have_r, bvalid_r, rvalid_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r, rdata_r, wmask, wval, rd_nxt;
  logic [3:0]  w_strb_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [2:0]  wsel, rsel;
  logic        do_write;

  logic [1:0]  ph_r;
  logic        bclk_r, fall_ev, rise_ev;
  logic        trig_q_r, trig2_q_r, edge1, edge2;
  logic        latch_r, latch2_r, pend_r, pend2_r, wait_r, wait2_r;
  logic        single_r, start, stop_ev, last;
  state_type   state_r, state_nxt;
  logic [4:0]  pos_r, pos_nxt;
  logic [3:0]  sym_r, sym_nxt;
  logic        data_r, sync_r, m3_r, m4_r, wtrig_r, m3_on, m4_on;

  // ==========================================================================
  // AXI4-Lite write channel: address and data taken in either order
  assign S_AXI_AWREADY = ~aw_have_r & ~bvalid_r;
  assign S_AXI_WREADY  = ~w_have_r & ~bvalid_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign do_write      = aw_have_r & w_have_r & ~bvalid_r;
  assign wsel          = decode(aw_addr_r);

  // byte lane mask from the write strobes
  generate
    for (genvar i = 0; i < 4; i++) begin : g_mask
      assign wmask[8*i +: 8] = {8{w_strb_r[i]}};
    end
  endgenerate

  // merge helper for read-modify-write of strobed lanes
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (wsel)
      SEL_CTRL:    rd_nxt = {25'h0, ctrl_r};
      SEL_SEQ_EN:  rd_nxt = {30'h0, seq_en_r};
      SEL_PATTERN: rd_nxt = pattern_r;
      SEL_LENGTH:  rd_nxt = {20'h0, slen_r, 3'h0, plen_r};
      SEL_MKR:     rd_nxt = {30'h0, mkr_mem[aw_addr_r[6:2]]};
      default:     rd_nxt = 32'h0000_0000;
    endcase
    wval = (rd_nxt & ~wmask) | (w_data_r & wmask);
  end

  // write handshake and response
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_r && S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // control registers; status is read only
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_r    <= CTRL_RST;
      seq_en_r  <= SEQ_EN_RST;
      pattern_r <= PATTERN_RST;
      plen_r    <= PLEN_RST;
      slen_r    <= SLEN_RST;
    end else if (do_write) begin
      case (wsel)
        SEL_CTRL:    ctrl_r    <= ctrl_type'(wval[6:0]);
        SEL_SEQ_EN:  seq_en_r  <= wval[1:0];  // explicit re-enable
        SEL_PATTERN: pattern_r <= wval;
        SEL_LENGTH: begin
          plen_r <= wval[4:0];
          slen_r <= wval[11:8];
        end
        default: ;
      endcase
    end
  end

  // per-point marker flags, bit 0 third marker, bit 1 fourth marker
  always_ff @(posedge CLK) begin
    if (do_write && wsel == SEL_MKR) begin
      mkr_mem[aw_addr_r[6:2]] <= wval[1:0];
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel: answer one cycle after the address
  assign S_AXI_ARREADY = ~rvalid_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;
  assign rsel          = decode(S_AXI_ARADDR);

  always_ff @(posedge CLK) begin
    if (RST) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_r <= 1'b1;
      rresp_r  <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (rsel)
        SEL_CTRL:    rdata_r <= {25'h0, ctrl_r};
        SEL_SEQ_EN:  rdata_r <= {30'h0, seq_en_r};
        SEL_PATTERN: rdata_r <= pattern_r;
        SEL_LENGTH:  rdata_r <= {20'h0, slen_r, 3'h0, plen_r};
        SEL_STATUS:  rdata_r <= {19'h0, sym_r, pos_r, single_r, wait_r,
                                 pend_r, state_r};
        SEL_MKR:     rdata_r <= {30'h0, mkr_mem[S_AXI_ARADDR[6:2]]};
        default:     rdata_r <= 32'h0000_0000;
      endcase
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================================
  // data bit clock: high for the first half of each bit
  assign fall_ev = (ph_r == PH_FALL);
  assign rise_ev = (ph_r == PH_RISE);

  always_ff @(posedge CLK) begin
    if (RST) begin
      ph_r   <= 2'h0;
      bclk_r <= 1'b1;
    end else begin
      ph_r   <= ph_r + 2'h1;
      bclk_r <= rise_ev | (ph_r < PH_FALL);
    end
  end
  assign DATA_CLK_OUT = bclk_r;

  // ==========================================================================
  // trigger edge capture, latch and bit-clock alignment
  assign edge1 = edge_hit(trig_q_r, PATTERN_TRIGGER_INPUT, ctrl_r.edge_fall);
  assign edge2 = edge_hit(trig2_q_r, SECOND_PATTERN_TRIGGER_INPUT,
                          ctrl_r.edge_fall);

  always_ff @(posedge CLK) begin
    if (RST) begin
      trig_q_r  <= 1'b0;
      trig2_q_r <= 1'b0;
      latch_r   <= 1'b0;
      latch2_r  <= 1'b0;
      pend_r    <= 1'b0;
      pend2_r   <= 1'b0;
      wait_r    <= 1'b0;
      wait2_r   <= 1'b0;
    end else begin
      trig_q_r  <= PATTERN_TRIGGER_INPUT;
      trig2_q_r <= SECOND_PATTERN_TRIGGER_INPUT;
      // a new edge wins over the clear by the sampling edge
      latch_r  <= edge1 | edge2 | (latch_r & ~fall_ev);
      latch2_r <= edge2 | (latch2_r & ~fall_ev);
      if (fall_ev) begin
        pend_r  <= latch_r;
        pend2_r <= latch2_r;
      end else if (rise_ev) begin
        pend_r  <= 1'b0;
        pend2_r <= 1'b0;
      end
      if (rise_ev) begin
        wait_r  <= pend_r;  // extra bit gives 1.75..2.75 bits
        wait2_r <= pend2_r;
      end
    end
  end

  assign start   = rise_ev & wait_r;
  assign stop_ev = fall_ev & latch_r & (state_r == ST_RUN);

  // ==========================================================================
  // pattern sequencer
  assign last = (pos_r == plen_r);

  always_comb begin
    state_nxt = state_r;
    pos_nxt   = pos_r;
    sym_nxt   = sym_r;
    if (stop_ev) begin
      state_nxt = ST_IDLE;
    end else if (start) begin
      state_nxt = ST_RUN;  // restart from bit zero
      pos_nxt   = 5'h00;
      sym_nxt   = 4'h0;
    end else if (rise_ev && state_r == ST_RUN) begin
      pos_nxt = last ? 5'h00 : pos_r + 5'h01;
      sym_nxt = (sym_r == slen_r || last) ? 4'h0 : sym_r + 4'h1;
      if (last && (!ctrl_r.continuous || single_r)) begin
        state_nxt = ST_IDLE;  // single pattern done
      end
    end
  end

  // sequencer state
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r  <= ST_IDLE;
      pos_r    <= 5'h00;
      sym_r    <= 4'h0;
      single_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pos_r   <= pos_nxt;
      sym_r   <= sym_nxt;
      if (start) begin
        single_r <= wait2_r;  // second input forces one pass
      end
    end
  end

  // markers follow the point flags, gated by sequence enables
  assign m3_on = ctrl_r.wave_mode & mkr_mem[pos_nxt][0]
               & (~ctrl_r.seq_mode | seq_en_r[0]);
  assign m4_on = ctrl_r.wave_mode & mkr_mem[pos_nxt][1]
               & (~ctrl_r.seq_mode | seq_en_r[1]);

  // serial outputs change at each bit boundary, and go idle at once on a stop at the bit clock falling edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      data_r  <= 1'b0;
      sync_r  <= 1'b0;
      m3_r    <= 1'b0;
      m4_r    <= 1'b0;
      wtrig_r <= 1'b0;
    end else begin
      wtrig_r <= start & ctrl_r.wave_mode;
      if (stop_ev) begin
        data_r <= 1'b0;
        sync_r <= 1'b0;
        m3_r   <= ctrl_r.pol3_neg;
        m4_r   <= ctrl_r.pol4_neg;
      end else if (rise_ev) begin
        if (state_nxt == ST_RUN) begin
          data_r <= ctrl_r.src_ext ? EXT_DATA_IN
                                   : pattern_r[pos_nxt];
          sync_r <= (sym_nxt == 4'h0);
          m3_r   <= m3_on ^ ctrl_r.pol3_neg;
          m4_r   <= m4_on ^ ctrl_r.pol4_neg;
        end else begin
          data_r <= 1'b0;
          sync_r <= 1'b0;
          m3_r   <= ctrl_r.pol3_neg;
          m4_r   <= ctrl_r.pol4_neg;
        end
      end
    end
  end

  assign DATA_OUT           = data_r;
  assign SYMBOL_SYNC_OUTPUT = sync_r;
  assign MARKER3_OUT        = m3_r;
  assign MARKER4_OUT        = m4_r;
  assign WAVE_TRIG_OUT      = wtrig_r;

  // ==========================================================================
  // assertions
  a_edge_select: assert property (@(posedge CLK) disable iff (RST)
    (ctrl_r.edge_fall && trig_q_r && !PATTERN_TRIGGER_INPUT) |=> latch_r)
    else $error("falling trigger edge not latched");

  a_stop_resync: assert property (@(posedge CLK) disable iff (RST)
    stop_ev |=> state_r == ST_IDLE ##0 !data_r)
    else $error("retrigger did not stop the pattern");

  a_fall_sample: assert property (@(posedge CLK) disable iff (RST)
    $rose(pend_r) |-> $past(ph_r) == PH_FALL)
    else $error("trigger sampled off the falling bit clock edge");

  a_trig_latency: assert property (@(posedge CLK) disable iff (RST)
    (edge1 && !latch_r && !pend_r && !wait_r) |-> ##[6:10] start)
    else $error("trigger to first bit latency out of range");

  a_wave_trig: assert property (@(posedge CLK) disable iff (RST)
    (start && ctrl_r.wave_mode) |=> WAVE_TRIG_OUT)
    else $error("waveform trigger pulse missing");

  a_marker4_level: assert property (@(posedge CLK) disable iff (RST)
    (rise_ev && !stop_ev && state_nxt == ST_RUN && m4_on)
      |=> MARKER4_OUT == !ctrl_r.pol4_neg)
    else $error("fourth marker level wrong");

  a_seq_disable: assert property (@(posedge CLK) disable iff (RST)
    (rise_ev && !stop_ev && ctrl_r.seq_mode && !seq_en_r[0])
      |=> MARKER3_OUT == $past(ctrl_r.pol3_neg))
    else $error("sequence marker not disabled");

  a_sync_width: assert property (@(posedge CLK) disable iff (RST)
    $rose(sync_r) |-> sync_r [*4])
    else $error("symbol sync shorter than one bit");

  a_bit_clock: assert property (@(posedge CLK) disable iff (RST)
    rise_ev |=> bclk_r [*2] ##1 !bclk_r [*2])
    else $error("bit clock waveform wrong");

  a_ext_data: assert property (@(posedge CLK) disable iff (RST)
    (rise_ev && !stop_ev && state_nxt == ST_RUN && ctrl_r.src_ext)
      |=> DATA_OUT == $past(EXT_DATA_IN))
    else $error("external data not passed through");

endmodule
`default_nettype wire

// ==== verification/trig_equipment.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// external equipment: trigger lines and serial data source
module trig_equipment (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic go,
  input  wire logic sel,
  input  wire logic idle_hi,
  input  wire logic ext_lvl,
  output logic      trig_a,
  output logic      trig_b,
  output logic      ext_data
);
  logic [1:0] cnt_r;

  // pulse lasts two cycles, wider than the minimum pulse width
  always_ff @(posedge CLK) begin
    if (RST)
      cnt_r <= 2'h0;
    else if (go)
      cnt_r <= 2'h2;
    else if (cnt_r != 2'h0)
      cnt_r <= cnt_r - 2'h1;
  end

  // active pulse is the inverse of the idle level
  assign trig_a   = idle_hi ^ ((cnt_r != 2'h0) && !sel);
  assign trig_b   = idle_hi ^ ((cnt_r != 2'h0) && sel);
  assign ext_data = ext_lvl;
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pattern_trigger_pkg::*;
  logic clk, rst, go, sel, idle_hi, ext_lvl, trg_a, trg_b, ed;
  logic dclk, dout, sync, m3, m4, wtrig;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, pat, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, seq_en;
  logic awv, awrdy, wv, wrdy, bv, bready, arv, arrdy, rv, rready;
  logic [1:0] flags [32];
  logic [15:0] lf, v;
  ctrl_type cfg;
  int err_count, compares, slen;

  pattern_trigger_marker_io DUT (.CLK(clk), .RST(rst),
    .PATTERN_TRIGGER_INPUT(trg_a), .SECOND_PATTERN_TRIGGER_INPUT(trg_b),
    .EXT_DATA_IN(ed), .DATA_CLK_OUT(dclk), .DATA_OUT(dout),
    .SYMBOL_SYNC_OUTPUT(sync), .MARKER3_OUT(m3), .MARKER4_OUT(m4),
    .WAVE_TRIG_OUT(wtrig), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready));

  trig_equipment EQ (.CLK(clk), .RST(rst), .go(go), .sel(sel),
    .idle_hi(idle_hi), .ext_lvl(ext_lvl), .trig_a(trg_a),
    .trig_b(trg_b), .ext_data(ed));

  // clock 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ============================================================
  // helpers
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  function automatic logic [31:0] len_word(input int nb, input int sl);
    return {20'h0, 4'(sl - 1), 3'h0, 5'(nb - 1)};
  endfunction

  function automatic logic exp_data(input int i);
    return cfg.src_ext ? ext_lvl : pat[i];
  endfunction

  function automatic logic exp_mk(input int i, input int k);
    logic pol;
    logic en;
    pol = (k == 1) ? cfg.pol4_neg : cfg.pol3_neg;
    en  = cfg.seq_mode ? seq_en[k] : 1'b1;
    return pol ^ (flags[i][k] & en);
  endfunction

  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ============================================================
  // register bus master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] x,
                        input logic [3:0] s, output logic [1:0] rs);
    int n;
    logic haw, hw, done;
    awaddr <= a; wdata <= x; wstrb <= s;
    awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
    n = 0;
    // sample the handshakes while settled, act just after the edge
    do begin
      @(negedge clk);
      haw = awv && awrdy;
      hw = wv && wrdy;
      done = bready && bv;
      rs = bresp;
      @(posedge clk);
      n++;
      if (haw) awv <= 1'b0;
      if (hw) wv <= 1'b0;
    end while (!done && n < 64);
    if (!done) err_count++;
    awv <= 1'b0; wv <= 1'b0;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] x,
                        output logic [1:0] rs);
    int n;
    logic har, done;
    araddr <= a; arv <= 1'b1; rready <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      har = arv && arrdy;
      done = rready && rv;
      x = rdata;
      rs = rresp;
      @(posedge clk);
      n++;
      if (har) arv <= 1'b0;
    end while (!done && n < 64);
    if (!done) err_count++;
    arv <= 1'b0;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    logic [1:0] rs;
    axi_wr(a, x, 4'hf, rs);
    check("write resp", RESP_OKAY, rs);
  endtask

  // ============================================================
  // one triggered frame, checked bit by bit
  task automatic frame(input logic s, input int nb, input logic idle);
    int n, w;
    logic [3:0] ck;
    w = 0;
    go <= 1'b1; sel <= s;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      w += int'(wtrig);
    end while (sync !== 1'b1 && n < 20);
    check("latency ok", 32'h1, {31'h0, n >= 10 && n <= 13});
    for (int i = 0; i < nb; i++) begin
      for (int j = 0; j < 4; j++) begin
        if (j > 0) @(negedge clk);
        ck[j] = dclk;
        if (i > 0 || j > 0) w += int'(wtrig);
        check("data", exp_data(i), dout);
        check("sync", (i % slen) == 0, sync);
        if (cfg.wave_mode) begin
          check("marker3", exp_mk(i, 0), m3);
          check("marker4", exp_mk(i, 1), m4);
        end
      end
      check("bit clock", 32'h1, {31'h0, ck[0] == ck[1] &&
            ck[2] == ck[3] && ck[0] != ck[2]});
      @(negedge clk);
    end
    check("wave triggers", cfg.wave_mode, w);
    if (idle) repeat (8) begin
      @(negedge clk);
      check("idle sync", 32'h0, sync);
      check("idle data", 32'h0, dout);
    end
    @(posedge clk);
  endtask

  // watchdog cuts a hang short
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    $display("watchdog expired");
    give_verdict();
  end

  // ============================================================
  // main sequence
  initial begin
    rst = 1'b1; go = 1'b0; sel = 1'b0; idle_hi = 1'b0; ext_lvl = 1'b0;
    awaddr = 8'h0; awv = 1'b0; wdata = 32'h0; wstrb = 4'h0; wv = 1'b0;
    bready = 1'b0; araddr = 8'h0; arv = 1'b0; rready = 1'b0;
    lf = 16'h0056; cfg = CTRL_RST; seq_en = 2'h0; slen = 4;
    err_count = 0; compares = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    axi_rd(OFF_CTRL, d, r);
    check("ctrl reset", 32'h0, d);
    axi_rd(OFF_LENGTH, d, r);
    check("length reset", {20'h0, SLEN_RST, 3'h0, PLEN_RST}, d);
    axi_rd(OFF_SEQ_EN, d, r);
    check("seq_en reset", 32'h0, d);
    axi_rd(8'h40, d, r);
    check("unmapped read", RESP_SLVERR, r);
    axi_wr(8'h44, 32'h1, 4'hf, r);
    check("unmapped write", RESP_SLVERR, r);
    pat = {rnd(), rnd()};
    wr(OFF_PATTERN, pat);
    axi_wr(OFF_PATTERN, 32'h0000_00a5, 4'h1, r);
    axi_rd(OFF_PATTERN, d, r);
    check("strobed write", {pat[31:8], 8'ha5}, d);
    axi_wr(OFF_STATUS, 32'hffff_ffff, 4'hf, r);
    axi_rd(OFF_STATUS, d, r);
    check("status idle", 32'h0, {31'h0, d[0]});
    $display("test registers done");
    wr(OFF_LENGTH, len_word(8, 4));
    for (int e = 0; e < 2; e++) begin
      cfg.edge_fall = e[0];
      wr(OFF_CTRL, {25'h0, cfg});
      idle_hi <= e[0];
      repeat (16) begin
        @(negedge clk);
        check("no trigger", 32'h0, sync);
      end
      @(posedge clk);
      pat = {rnd(), rnd()};
      wr(OFF_PATTERN, pat);
      frame(1'b0, 8, 1'b1);
      $display("test edge %0d done", e);
    end
    cfg.wave_mode = 1'b1;
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      flags[i] = v[1:0];
      wr(8'(OFF_MKR_BASE + 8'(4 * i)), {30'h0, flags[i]});
    end
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      cfg.pol3_neg = v[0];
      cfg.pol4_neg = v[1];
      cfg.seq_mode = (k > 0);
      seq_en = (k > 0) ? 2'(k - 1) : 2'h0;
      wr(OFF_SEQ_EN, {30'h0, seq_en});
      wr(OFF_CTRL, {25'h0, cfg});
      frame(1'b0, 8, 1'b1);
    end
    $display("test markers done");
    cfg = CTRL_RST;
    cfg.edge_fall = 1'b1;
    cfg.src_ext = 1'b1;
    wr(OFF_CTRL, {25'h0, cfg});
    for (int x = 0; x < 2; x++) begin
      ext_lvl <= x[0];
      pat = x[0] ? 32'h0 : 32'hffff_ffff;
      wr(OFF_PATTERN, pat);
      frame(1'b0, 8, 1'b1);
    end
    $display("test external data done");
    cfg.src_ext = 1'b0;
    cfg.continuous = 1'b1;
    wr(OFF_CTRL, {25'h0, cfg});
    slen = 8;
    wr(OFF_LENGTH, len_word(8, 8));
    pat = {rnd(), rnd()};
    wr(OFF_PATTERN, pat);
    frame(1'b0, 3, 1'b0);
    frame(1'b0, 8, 1'b0);
    repeat (8) @(posedge clk);
    frame(1'b1, 8, 1'b1);
    $display("test resync done");
    give_verdict();
  end
endmodule
`default_nettype wire
